/* File: include/cbr_pkg.sv */
package cbr_pkg;

    // Register map, byte addresses on the AXI4-Lite slave.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BASE_ID = 8'h04;
    localparam logic [7:0] ADDR_MSG_GAP = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_BLK0 = 8'h10;
    localparam int BLK_STRIDE_BYTES = 16;
    localparam logic [1:0] BLK_DATA_PTR = 2'h0;
    localparam logic [1:0] BLK_GATE_PTR = 2'h1;
    localparam logic [1:0] BLK_STRIDE = 2'h2;
    localparam logic [1:0] BLK_COUNT = 2'h3;

    // Control bits.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_PASS_BIT = 1;

    // Identifier layout.
    localparam int ID_W = 11;
    localparam logic [10:0] BULK_ID_OFFSET = 11'h040;
    localparam logic [10:0] BASE_ID_RESET = 11'h100;

    // Pause between messages.
    localparam int CLK_MHZ = 50;
    localparam logic [15:0] MSG_GAP_US_RESET = 16'h03E8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        CBR_IDLE,
        CBR_READ_GATE,
        CBR_READ_DATA,
        CBR_SEND,
        CBR_PAUSE,
        CBR_NEXT
    } cbr_state_e;

endpackage : cbr_pkg

/* File: core/cbr_reporter.sv */
`timescale 1ns/1ps
// Overview of operation
// - Four independent bulk report blocks, indexed 0-3.
// - Bulk frames formatted like individual frames.
// - Zero start pointer silences that block.
// - Gate pointer register decides each transmission.
// - Both pointers advance by stride after each item.
// - Exactly item count gate registers read per live block per pass.
// - Block 0 identifiers start at base plus 64.
// - Consecutive identifiers, one per item, in order.
// - Later blocks follow all earlier blocks' identifiers.
// - Every counted slot occupies an identifier.
// - Identifiers allocated upward from configurable base.
// - Transmit only when gate register is nonzero.
// - Configurable microsecond pause between report messages.
module cbr_reporter #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 32,
    parameter int CNT_W = 16,
    parameter int NUM_BLK = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pass_start,
    output logic [ADDR_W-1:0] reg_addr,
    output logic reg_req,
    input wire logic reg_ack,
    input wire logic [DATA_W-1:0] reg_rdata,
    output logic [10:0] tx_id,
    output logic [DATA_W-1:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic pass_busy
);

    localparam int GAP_PER_US = cbr_pkg::CLK_MHZ;

    if (NUM_BLK != 4 || ADDR_W < 2 || ADDR_W > 32 || CNT_W < 1
        || CNT_W > 16 || DATA_W < 1)
    begin : bad_params
        $error("cbr_reporter: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    logic enable_ff;
    logic pass_req_ff;
    logic [10:0] base_id_ff;
    logic [15:0] gap_us_ff;
    logic [ADDR_W-1:0] dptr_ff [NUM_BLK];
    logic [ADDR_W-1:0] gptr_ff [NUM_BLK];
    logic [ADDR_W-1:0] stride_ff [NUM_BLK];
    logic [CNT_W-1:0] count_ff [NUM_BLK];
    logic [7:0] awaddr_ff;
    logic aw_held_ff;
    logic [31:0] wdata_ff;
    logic w_held_ff;
    logic wstrb_lo_ff;

    cbr_pkg::cbr_state_e state_ff;
    logic [1:0] blk_ff;
    logic [CNT_W-1:0] item_ff;
    logic [10:0] id_ff;
    logic [ADDR_W-1:0] cur_d_ff;
    logic [ADDR_W-1:0] cur_g_ff;
    logic [21:0] gap_cnt_ff;

    function automatic logic blk_hit(input logic [7:0] a);
        blk_hit = (a >= cbr_pkg::ADDR_BLK0)
            && (a < cbr_pkg::ADDR_BLK0 + 8'(NUM_BLK * 16));
    endfunction : blk_hit

    // Any mapped register, used by both the write and the read channel.
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = blk_hit(a) || a == cbr_pkg::ADDR_CTRL
            || a == cbr_pkg::ADDR_BASE_ID || a == cbr_pkg::ADDR_MSG_GAP
            || a == cbr_pkg::ADDR_STATUS;
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order.
    wire wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
    wire [7:0] wa_blk = awaddr_ff - cbr_pkg::ADDR_BLK0;
    wire wa_in_blk = blk_hit(awaddr_ff);
    wire [1:0] wa_idx = wa_blk[5:4];
    wire [1:0] wa_fld = wa_blk[3:2];
    wire wa_ok = reg_hit(awaddr_ff);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_lo_ff <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cbr_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_lo_ff <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wa_ok ? cbr_pkg::RESP_OKAY
                                     : cbr_pkg::RESP_DECERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid && aresetn && clk_en;
    assign s_axi_wready = !w_held_ff && !s_axi_bvalid && aresetn && clk_en;

    // Configuration registers; only low 16 bits of fields are used.
    wire pass_done = state_ff == cbr_pkg::CBR_NEXT && blk_ff == 2'(NUM_BLK-1);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_ff <= 1'b0;
            pass_req_ff <= 1'b0;
            base_id_ff <= cbr_pkg::BASE_ID_RESET;
            gap_us_ff <= cbr_pkg::MSG_GAP_US_RESET;
            for (int i = 0; i < NUM_BLK; i++)
            begin
                dptr_ff[i] <= '0;
                gptr_ff[i] <= '0;
                stride_ff[i] <= '0;
                count_ff[i] <= '0;
            end
        end
        else if (clk_en)
        begin
            if (pass_start || (wr_go && awaddr_ff == cbr_pkg::ADDR_CTRL
                && wstrb_lo_ff && wdata_ff[cbr_pkg::CTRL_PASS_BIT]))
                pass_req_ff <= 1'b1;
            else if (state_ff == cbr_pkg::CBR_IDLE && pass_req_ff)
                pass_req_ff <= 1'b0;
            if (wr_go && wstrb_lo_ff && awaddr_ff == cbr_pkg::ADDR_CTRL)
                enable_ff <= wdata_ff[cbr_pkg::CTRL_ENABLE_BIT];
            if (wr_go && awaddr_ff == cbr_pkg::ADDR_BASE_ID)
                base_id_ff <= wdata_ff[10:0];
            if (wr_go && awaddr_ff == cbr_pkg::ADDR_MSG_GAP)
                gap_us_ff <= wdata_ff[15:0];
            if (wr_go && wa_in_blk)
            begin
                unique case (wa_fld)
                    cbr_pkg::BLK_DATA_PTR: dptr_ff[wa_idx] <= wdata_ff[ADDR_W-1:0];
                    cbr_pkg::BLK_GATE_PTR: gptr_ff[wa_idx] <= wdata_ff[ADDR_W-1:0];
                    cbr_pkg::BLK_STRIDE: stride_ff[wa_idx] <= wdata_ff[ADDR_W-1:0];
                    cbr_pkg::BLK_COUNT: count_ff[wa_idx] <= wdata_ff[CNT_W-1:0];
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel.
    wire [7:0] ra_blk = s_axi_araddr - cbr_pkg::ADDR_BLK0;
    wire [1:0] ra_idx = ra_blk[5:4];
    wire [31:0] ra_blk_val =
        ra_blk[3:2] == cbr_pkg::BLK_DATA_PTR ? 32'(dptr_ff[ra_idx]) :
        ra_blk[3:2] == cbr_pkg::BLK_GATE_PTR ? 32'(gptr_ff[ra_idx]) :
        ra_blk[3:2] == cbr_pkg::BLK_STRIDE ? 32'(stride_ff[ra_idx]) :
        32'(count_ff[ra_idx]);
    wire [31:0] status_val = {16'h0000, 3'(state_ff), 2'(blk_ff),
        11'(id_ff)};
    wire ra_ok = reg_hit(s_axi_araddr);
    wire [31:0] ra_val =
        blk_hit(s_axi_araddr) ? ra_blk_val :
        s_axi_araddr == cbr_pkg::ADDR_CTRL ? {30'h0, pass_busy, enable_ff} :
        s_axi_araddr == cbr_pkg::ADDR_BASE_ID ? {21'h0, base_id_ff} :
        s_axi_araddr == cbr_pkg::ADDR_MSG_GAP ? {16'h0000, gap_us_ff} :
        s_axi_araddr == cbr_pkg::ADDR_STATUS ? status_val : 32'h0000_0000;

    assign s_axi_arready = !s_axi_rvalid && aresetn && clk_en;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= cbr_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= ra_val;
                s_axi_rresp <= ra_ok ? cbr_pkg::RESP_OKAY
                                     : cbr_pkg::RESP_DECERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Report walker.
    wire blk_live = dptr_ff[blk_ff] != '0 && count_ff[blk_ff] != '0;
    wire [21:0] gap_cycles = 22'(gap_us_ff) * 22'(GAP_PER_US);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= cbr_pkg::CBR_IDLE;
            blk_ff <= 2'h0;
            item_ff <= '0;
            id_ff <= 11'h000;
            cur_d_ff <= '0;
            cur_g_ff <= '0;
            gap_cnt_ff <= 22'h00_0000;
            reg_req <= 1'b0;
            reg_addr <= '0;
            tx_valid <= 1'b0;
            tx_id <= 11'h000;
            tx_data <= '0;
            pass_busy <= 1'b0;
        end
        else if (clk_en)
        begin
            if (gap_cnt_ff != 22'h00_0000)
                gap_cnt_ff <= gap_cnt_ff - 22'h00_0001;
            unique case (state_ff)
                cbr_pkg::CBR_IDLE:
                    if (pass_req_ff && enable_ff)
                    begin
                        pass_busy <= 1'b1;
                        blk_ff <= 2'h0;
                        item_ff <= '0;
                        id_ff <= base_id_ff + cbr_pkg::BULK_ID_OFFSET;
                        cur_d_ff <= dptr_ff[0];
                        cur_g_ff <= gptr_ff[0];
                        state_ff <= cbr_pkg::CBR_NEXT;
                    end
                cbr_pkg::CBR_READ_GATE:
                    if (reg_ack)
                    begin
                        reg_req <= 1'b0;
                        if (reg_rdata != '0)
                            state_ff <= cbr_pkg::CBR_READ_DATA;
                        else
                            state_ff <= cbr_pkg::CBR_PAUSE;
                    end
                cbr_pkg::CBR_READ_DATA:
                    if (!reg_req)
                    begin
                        reg_req <= 1'b1;
                        reg_addr <= cur_d_ff;
                    end
                    else if (reg_ack)
                    begin
                        reg_req <= 1'b0;
                        tx_data <= reg_rdata;
                        tx_id <= id_ff;
                        state_ff <= cbr_pkg::CBR_SEND;
                    end
                cbr_pkg::CBR_SEND:
                    if (!tx_valid && gap_cnt_ff == 22'h00_0000)
                        tx_valid <= 1'b1;
                    else if (tx_valid && tx_ready)
                    begin
                        tx_valid <= 1'b0;
                        gap_cnt_ff <= gap_cycles;
                        state_ff <= cbr_pkg::CBR_PAUSE;
                    end
                cbr_pkg::CBR_PAUSE:
                begin
                    // Skipped items still consume an identifier.
                    id_ff <= id_ff + 11'h001;
                    item_ff <= item_ff + CNT_W'(1);
                    cur_d_ff <= cur_d_ff + stride_ff[blk_ff];
                    cur_g_ff <= cur_g_ff + stride_ff[blk_ff];
                    state_ff <= cbr_pkg::CBR_NEXT;
                end
                cbr_pkg::CBR_NEXT:
                    if (item_ff != '0 && item_ff == count_ff[blk_ff]
                        || !blk_live || item_ff > count_ff[blk_ff])
                    begin
                        // Silent blocks still reserve their span.
                        if (!blk_live)
                            id_ff <= id_ff + 11'(count_ff[blk_ff]);
                        if (blk_ff == 2'(NUM_BLK-1))
                        begin
                            pass_busy <= 1'b0;
                            state_ff <= cbr_pkg::CBR_IDLE;
                        end
                        else
                        begin
                            blk_ff <= blk_ff + 2'h1;
                            item_ff <= '0;
                            cur_d_ff <= dptr_ff[blk_ff + 2'h1];
                            cur_g_ff <= gptr_ff[blk_ff + 2'h1];
                        end
                    end
                    else
                    begin
                        reg_req <= 1'b1;
                        reg_addr <= cur_g_ff;
                        state_ff <= cbr_pkg::CBR_READ_GATE;
                    end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    id_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && state_ff == cbr_pkg::CBR_PAUSE |=> id_ff == $past(id_ff) + 11'h001)
        else $error("identifier did not step by one");
    first_id_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && state_ff == cbr_pkg::CBR_IDLE && pass_req_ff && enable_ff
        |=> id_ff == base_id_ff + cbr_pkg::BULK_ID_OFFSET)
        else $error("first identifier not base plus 64");
    stride_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && state_ff == cbr_pkg::CBR_PAUSE
        |=> cur_g_ff == $past(cur_g_ff) + $past(stride_ff[blk_ff]))
        else $error("gate pointer did not advance by stride");
    gate_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && state_ff == cbr_pkg::CBR_READ_GATE && reg_ack
        && reg_rdata == '0 |=> state_ff != cbr_pkg::CBR_READ_DATA)
        else $error("message read despite closed gate");
    silent_blk_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && state_ff == cbr_pkg::CBR_NEXT && dptr_ff[blk_ff] == '0
        |=> state_ff != cbr_pkg::CBR_READ_GATE)
        else $error("block with zero pointer was walked");
    tx_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_id) && $stable(tx_data))
        else $error("frame changed while waiting");
    gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        gap_cnt_ff != 22'h00_0000 |-> !(tx_valid && !$past(tx_valid)))
        else $error("frame offered during pause");
    order_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && state_ff == cbr_pkg::CBR_NEXT && !pass_done
        |=> blk_ff == $past(blk_ff) || blk_ff == $past(blk_ff) + 2'h1)
        else $error("blocks not visited in index order");

endmodule : cbr_reporter

/* File: bench/cbr_regspace.sv */
`timescale 1ns/1ps
// Register space behind the reporter: answers each read promptly or slowly.
module cbr_regspace (
    input wire logic aclk,
    input wire logic slow,
    input wire logic [15:0] reg_addr,
    input wire logic reg_req,
    output logic reg_ack,
    output logic [31:0] reg_rdata
);
    logic [2:0] wait_ff = 3'h0;
    initial reg_ack = 1'b0;
    initial reg_rdata = 32'h0;
    // Every eighth register reads zero, so it acts as a closed gate.
    function automatic logic [31:0] reg_value(input logic [15:0] a);
        return (a[2:0] == 3'h7) ? 32'h0 : {a, ~a};
    endfunction : reg_value
    // One answer per request; data toggles while no answer stands.
    always @(posedge aclk)
    begin
        reg_ack <= 1'b0;
        reg_rdata <= ~reg_rdata;
        wait_ff <= 3'h0;
        if (reg_req && !reg_ack)
        begin
            wait_ff <= wait_ff + 3'h1;
            if (wait_ff >= (slow ? 3'h4 : 3'h0))
            begin
                reg_ack <= 1'b1;
                reg_rdata <= reg_value(reg_addr);
            end
        end
    end
endmodule : cbr_regspace

/* File: bench/can_bulk_register_reporter_bench.sv */
`timescale 1ns/1ps
module can_bulk_register_reporter_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rr, seed = 32'h3B28645E;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, pass_start = 1'b0, tx_ready = 1'b0, slow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, reg_req, reg_ack;
    logic tx_valid, pass_busy, valid_q = 1'b0;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, reg_rdata, tx_data;
    logic [15:0] reg_addr, gap_us;
    logic [10:0] tx_id, base_id;
    logic [15:0] dptr[4], gptr[4], strd[4], cnt[4];
    logic [10:0] exp_id[$];
    logic [31:0] exp_data[$];
    int mismatches = 0, checked = 0, cycles = 0;
    int reads_seen = 0, reads_exp = 0, gap_cnt = 100000, gap_need = 0;
    logic clk_en = 1'b1;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] cfg_rr;

    cbr_reporter uut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pass_start(pass_start), .reg_addr(reg_addr), .reg_req(reg_req),
        .reg_ack(reg_ack), .reg_rdata(reg_rdata), .tx_id(tx_id),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .pass_busy(pass_busy)
    );
    cbr_regspace model (
        .aclk(aclk), .slow(slow), .reg_addr(reg_addr), .reg_req(reg_req),
        .reg_ack(reg_ack), .reg_rdata(reg_rdata)
    );

    initial
    begin
        forever #10 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er,
                          input logic [31:0] ed);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        check({30'h0, rresp}, {30'h0, er});
        check(rdata, ed);
    endtask : axi_rd

    function automatic logic [7:0] blk_a(input int b, input int k);
        return 8'(cbr_pkg::ADDR_BLK0 + cbr_pkg::BLK_STRIDE_BYTES * b + 4 * k);
    endfunction : blk_a

    function automatic void build_exp();
        logic [10:0] id;
        id = base_id + cbr_pkg::BULK_ID_OFFSET;
        reads_exp = 0;
        for (int b = 0; b < 4; b++)
        begin
            for (int i = 0; i < int'(cnt[b]); i++)
            begin
                if (dptr[b] != 16'h0)
                begin
                    reads_exp++;
                    if (model.reg_value(16'(gptr[b] + i * strd[b])) != 0)
                    begin
                        reads_exp++;
                        exp_id.push_back(id);
                        exp_data.push_back(
                            model.reg_value(16'(dptr[b] + i * strd[b])));
                    end
                end
                id++;
            end
        end
    endfunction : build_exp

    task automatic run_pass(input logic by_pin, input string name);
        axi_wr(cbr_pkg::ADDR_BASE_ID, {21'h0, base_id}, cbr_pkg::RESP_OKAY);
        axi_wr(cbr_pkg::ADDR_MSG_GAP, {16'h0, gap_us}, cbr_pkg::RESP_OKAY);
        for (int b = 0; b < 4; b++)
        begin
            axi_wr(blk_a(b, 0), {16'h0, dptr[b]}, cbr_pkg::RESP_OKAY);
            axi_wr(blk_a(b, 1), {16'h0, gptr[b]}, cbr_pkg::RESP_OKAY);
            axi_wr(blk_a(b, 2), {16'h0, strd[b]}, cbr_pkg::RESP_OKAY);
            axi_wr(blk_a(b, 3), {16'h0, cnt[b]}, cbr_pkg::RESP_OKAY);
        end
        axi_rd(blk_a(3, 1), cbr_pkg::RESP_OKAY, {16'h0, gptr[3]});
        build_exp();
        reads_seen = 0;
        if (by_pin)
        begin
            @(posedge aclk);
            pass_start <= 1'b1;
            @(posedge aclk);
            pass_start <= 1'b0;
        end
        else
            axi_wr(cbr_pkg::ADDR_CTRL, 32'h3, cbr_pkg::RESP_OKAY);
        while (pass_busy !== 1'b1)
            @(posedge aclk);
        while (pass_busy !== 1'b0)
            @(posedge aclk);
        repeat (2) @(posedge aclk);
        check(32'(reads_seen), 32'(reads_exp));
        check(32'(exp_id.size()), 32'h0);
        axi_rd(cbr_pkg::ADDR_CTRL, cbr_pkg::RESP_OKAY, 32'h1);
        $display("test %s done", name);
    endtask : run_pass

    ////////////////////////////////////////////////////////////////////////
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            mismatches++;
            report_and_stop();
        end
        rr = rnd();
        tx_ready <= rr[0] | rr[1];
        if (reg_ack)
            reads_seen++;
        if (tx_valid && !valid_q)
            check(32'(gap_cnt >= gap_need), 32'h1);
        valid_q = tx_valid;
        gap_cnt++;
        if (tx_valid && tx_ready)
        begin
            gap_cnt = 0;
            gap_need = 50 * int'(gap_us);
            if (exp_id.size() == 0)
                check(32'h0, 32'h1);
            else
            begin
                check({21'h0, tx_id}, {21'h0, exp_id.pop_front()});
                check(tx_data, exp_data.pop_front());
            end
        end
    end

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(cbr_pkg::ADDR_BASE_ID, cbr_pkg::RESP_OKAY,
               {21'h0, cbr_pkg::BASE_ID_RESET});
        axi_rd(cbr_pkg::ADDR_MSG_GAP, cbr_pkg::RESP_OKAY,
               {16'h0, cbr_pkg::MSG_GAP_US_RESET});
        axi_rd(8'h50, cbr_pkg::RESP_DECERR, 32'h0);
        axi_wr(8'hFC, 32'h1, cbr_pkg::RESP_DECERR);
        wstrb <= 4'h0;
        axi_wr(cbr_pkg::ADDR_CTRL, 32'h3, cbr_pkg::RESP_OKAY);
        axi_rd(cbr_pkg::ADDR_CTRL, cbr_pkg::RESP_OKAY, 32'h0);
        wstrb <= 4'hF;
        axi_wr(cbr_pkg::ADDR_CTRL, 32'h1, cbr_pkg::RESP_OKAY);
        $display("test registers done");
        @(posedge aclk);
        clk_en <= 1'b0;
        pass_start <= 1'b1;
        repeat (3) @(posedge aclk);
        pass_start <= 1'b0;
        clk_en <= 1'b1;
        @(posedge aclk);
        check({31'h0, pass_busy}, 32'h0);
        $display("test freeze done");
        base_id = 11'h100;
        gap_us = 16'h1;
        dptr = '{16'h0200, 16'h0400, 16'h0, 16'h0};
        gptr = '{16'h0201, 16'h0401, 16'h0, 16'h0};
        strd = '{16'h6, 16'h4, 16'h0, 16'h0};
        cnt = '{16'h10, 16'h8, 16'h0, 16'h0};
        run_pass(1'b0, "standard");
        dptr = '{16'h0300, 16'h0, 16'h0500, 16'h0600};
        gptr = '{16'h000F, 16'h0111, 16'h0502, 16'h0601};
        strd = '{16'h8, 16'h1, 16'h3, 16'h2};
        cnt = '{16'h2, 16'h3, 16'h5, 16'h0};
        slow = 1'b1;
        run_pass(1'b1, "gaps");
        for (int p = 0; p < 4; p++)
        begin
            cfg_rr = rnd();
            base_id = {1'b0, cfg_rr[9:0]};
            gap_us = {15'h0, cfg_rr[10]} + 16'h1;
            slow = cfg_rr[11];
            for (int b = 0; b < 4; b++)
            begin
                cfg_rr = rnd();
                dptr[b] = (cfg_rr[3:0] == 4'h0) ? 16'h0 : cfg_rr[31:16];
                gptr[b] = {4'h0, cfg_rr[15:4]};
                strd[b] = {13'h0, cfg_rr[6:4]} + 16'h1;
                cnt[b] = {13'h0, cfg_rr[9:7]};
            end
            run_pass(cfg_rr[12], "random");
        end
        report_and_stop();
    end
endmodule : can_bulk_register_reporter_bench
